//--- hw/hbsdi_top.sv
// host bus serial disk interface: register decode, data buffer, serial link
// assumes all pins are synchronous to ref_clk and bus strobes are levels
// Overview of operation
// - top five bits high, jumper bits match
// - jumper in means zero, out means one
// - select only with sync and match
// - address bit one picks data buffer
// - buffer read drives eight, status five
// - writes keep all data drivers off
// - parallel load when not busy
// - shift on pulses while busy
// - buffer access sets run
// - run with done means command
// - init or busy clears run
// - busy when request and done low
// - eight bits then parity sent
// - status shows done, enable, request
// - error appears on bit fifteen
// - done and enable raise request
// - grant then bus free, take bus
// - master drives interrupt and vector
// - vector on lines eight to two
`timescale 1ns/1ps
`include "hbsdi_defines.svh"
module hbsdi_top #(
    parameter logic [9:0]  JUMPERS = `HBSDI_JUMPER_RESET, // 1 = jumper inserted
    parameter logic [15:0] VECTOR  = `HBSDI_VECTOR_RESET  // vector jumper image
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [17:0] addr,          // host address lines
    input  wire logic        master_sync,   // host sync strobe
    input  wire logic        c1,            // high = host writes
    input  wire logic [15:0] data_in,       // host data lines, received
    input  wire logic        bus_init,      // host initialise
    input  wire logic        grant_in,      // bus grant
    input  wire logic        bus_busy_in,   // bus busy from the bus
    input  wire logic        slave_sync_in, // slave sync from the bus
    input  wire logic        xfer_req,      // controller transfer request
    input  wire logic        ctl_done,      // controller done
    input  wire logic        ctl_out,       // controller direction, high = to us
    input  wire logic        ctl_error,     // controller error
    input  wire logic        shift_pulse,   // controller shift strobe
    input  wire logic        serial_in_bit, // serial data from controller
    input  wire logic        host_ready,    // host can take a read word
    output logic [15:0]      data_out,      // host data lines, driven
    output logic [15:0]      data_oe_n,     // per-line enable, low drives
    output logic             reg_select,    // address recognised
    output logic             run,           // run to the controller
    output logic             busy,          // serial busy
    output logic             serial_out_bit,// serial data to controller
    output logic             bus_request,   // bus request line
    output logic             bus_busy_out,  // we drive bus busy
    output logic             intr,          // interrupt line
    output logic             irq_enable,    // interrupt enable bit
    output logic             rd_valid       // assembled byte waiting
);
    // address decode
    wire top_ok  = &addr[`HBSDI_ADDR_TOP_HI:`HBSDI_ADDR_TOP_LO];
    wire [9:0] want_bits = ~JUMPERS;
    wire sel_ok  = (addr[`HBSDI_ADDR_SEL_HI:`HBSDI_ADDR_SEL_LO] == want_bits);
    wire sel_now = master_sync && top_ok && sel_ok;
    wire sel_db  = sel_now && addr[`HBSDI_ADDR_REG_BIT];
    wire sel_cs  = sel_now && !addr[`HBSDI_ADDR_REG_BIT];
    wire wr_db   = sel_db && c1;   // relied on: c1 marks writes
    wire wr_cs   = sel_cs && c1;
    wire rd_db   = sel_db && !c1;
    wire rd_cs   = sel_cs && !c1;

    // previous sync so each bus cycle acts once
    logic sync_q;
    wire  cyc_start = sel_now && !sync_q;

    // busy when neither request nor done
    wire busy_now = !xfer_req && !ctl_done;

    // shift register and serial framing
    logic [7:0] shreg;      // data buffer shift register
    logic [3:0] bit_cnt;    // bits of current frame
    logic       parity;     // running parity of sent bits
    logic       run_ff;     // run flip-flop
    logic       ie_ff;      // interrupt enable
    logic       err_seen;   // error latched until status read
    logic       rd_cs_q;    // status read seen on the previous edge

    // buffer between serial assembly and host read port
    hbsdi_buf_if #(.W(8)) asm_if ();
    hbsdi_buf_if #(.W(8)) rd_if ();
    logic       asm_valid;  // assembled byte offered to the buffer
    assign asm_if.valid = asm_valid;
    assign asm_if.data  = shreg;
    // a host data read while the host is ready pops the head word, once per cycle
    assign rd_if.ready  = host_ready && rd_db && cyc_start;

    hbsdi_skid #(.W(8)) u_skid (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .in_side  (asm_if),
        .out_side (rd_if)
    );

    // inbound frame completes after eight data bits
    wire in_dir   = ctl_out;
    wire shift_ok = busy_now && !wr_db;
    // stall inbound shifting while the buffer is full and an assembled byte still waits, so no byte is lost
    wire shift_go = shift_pulse && shift_ok && (!in_dir || asm_if.ready || !asm_valid);
    wire in_last  = in_dir && (bit_cnt == `HBSDI_DATA_BITS - 4'h1);
    wire out_par  = !in_dir && (bit_cnt == `HBSDI_DATA_BITS);

    // shift register: load or shift
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shreg <= 8'h00;
        end else if (wr_db && !busy_now) begin
            shreg <= data_in[7:0];
        end else if (shift_go && !out_par) begin
            shreg <= {shreg[6:0], in_dir ? serial_in_bit : 1'b0};
        end
    end

    // frame bit counter and parity; count restarts when busy falls
    always_ff @(posedge ref_clk) begin
        if (rst || !busy_now) begin
            bit_cnt <= 4'h0;
            parity  <= 1'b0;
        end else if (shift_go) begin
            // count bits and wrap after parity, or after the eighth bit inbound
            if (out_par || in_last) bit_cnt <= 4'h0;
            else bit_cnt <= bit_cnt + 4'h1;
            parity <= out_par ? 1'b0 : (parity ^ shreg[7]);
        end
    end

    // offer assembled inbound byte to the buffer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            asm_valid <= 1'b0;
        end else if (shift_go && in_last) begin
            asm_valid <= 1'b1;
        end else if (asm_if.ready) begin
            asm_valid <= 1'b0;
        end
    end

    // run flip-flop
    always_ff @(posedge ref_clk) begin
        if (rst || bus_init || busy_now) begin
            run_ff <= 1'b0;
        end else if (cyc_start && sel_db) begin
            run_ff <= 1'b1;
        end
    end

    // interrupt enable and error latch; a new error wins over the read clear
    always_ff @(posedge ref_clk) begin
        if (rst || bus_init) begin
            ie_ff    <= `HBSDI_IE_RESET;
            err_seen <= 1'b0;
            rd_cs_q  <= 1'b0;
        end else begin
            rd_cs_q <= rd_cs;
            if (wr_cs && cyc_start) ie_ff <= data_in[`HBSDI_CS_IE_BIT];
            if (ctl_error) err_seen <= 1'b1;
            // clear only once the status read is over, so bit fifteen stands for the whole cycle
            else if (rd_cs_q && !rd_cs) err_seen <= 1'b0;
        end
    end

    // arbitration
    logic arb_req;
    logic arb_master;
    hbsdi_arb u_arb (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .want          (ctl_done && ie_ff),
        .grant_in      (grant_in),
        .bus_busy_in   (bus_busy_in),
        .slave_sync_in (slave_sync_in),
        .bus_request   (arb_req),
        .master        (arb_master)
    );

    // read data selection
    // done, enable, request bits
    wire [15:0] cs_word = ({15'h0000, err_seen || ctl_error} << `HBSDI_CS_ERR_BIT)
                        | ({15'h0000, xfer_req} << `HBSDI_CS_TR_BIT)
                        | ({15'h0000, ie_ff}    << `HBSDI_CS_IE_BIT)
                        | ({15'h0000, ctl_done} << `HBSDI_CS_DONE_BIT);
    wire [15:0] db_word = {8'h00, rd_if.valid ? rd_if.data : shreg};
    wire [15:0] vec_mask = 16'h01fc;
    wire [15:0] vec_word = VECTOR & vec_mask;
    wire [15:0] next_data =
        arb_master ? vec_word : (rd_db ? db_word : (rd_cs ? cs_word : 16'h0000));
    // eight lines for buffer, four for status
    // status read also drives bit fifteen
    wire [15:0] next_oe_n =
        arb_master ? ~vec_mask :
        rd_db      ? 16'hff00 :
        rd_cs      ? 16'h7f0f : 16'hffff;

    // registered pin outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_q         <= 1'b0;
            data_out       <= 16'h0000;
            data_oe_n      <= 16'hffff;
            reg_select     <= 1'b0;
            run            <= 1'b0;
            busy           <= 1'b0;
            serial_out_bit <= 1'b0;
            bus_request    <= 1'b0;
            bus_busy_out   <= 1'b0;
            intr           <= 1'b0;
            irq_enable     <= `HBSDI_IE_RESET;
            rd_valid       <= 1'b0;
        end else begin
            sync_q         <= sel_now;
            data_out       <= next_data;
            data_oe_n      <= next_oe_n;
            reg_select     <= sel_now;
            run            <= run_ff;
            busy           <= busy_now;
            serial_out_bit <= out_par ? ~parity : shreg[7];
            bus_request    <= arb_req;
            bus_busy_out   <= arb_master;
            intr           <= arb_master;
            irq_enable     <= ie_ff;
            rd_valid       <= rd_if.valid;
        end
    end
endmodule

//--- common/hbsdi_defines.svh
// constants for the host bus serial disk interface
// assumes inclusion by bare name from any design or bench file
`ifndef HBSDI_DEFINES_SVH
`define HBSDI_DEFINES_SVH

// register offsets (byte addresses within the four-word decoded window, address bit 2 not decoded)
`define HBSDI_OFF_COMMAND_STATUS 18'h00000
`define HBSDI_OFF_DATA_BUFFER    18'h00002
// address field positions
`define HBSDI_ADDR_TOP_HI 17
`define HBSDI_ADDR_TOP_LO 13
`define HBSDI_ADDR_SEL_HI 12
`define HBSDI_ADDR_SEL_LO 3
`define HBSDI_ADDR_REG_BIT 1
// status bit positions on the data lines
`define HBSDI_CS_DONE_BIT  5
`define HBSDI_CS_IE_BIT    6
`define HBSDI_CS_TR_BIT    7
`define HBSDI_CS_ERR_BIT   15
// reset values
`define HBSDI_IE_RESET     1'b0
`define HBSDI_JUMPER_RESET 10'h000
// vector, octal 264, on data lines 8..2
`define HBSDI_VECTOR_RESET 16'h00b4
`define HBSDI_VEC_HI 8
`define HBSDI_VEC_LO 2
// serial byte: eight data bits then one parity bit
`define HBSDI_DATA_BITS 4'h8
`define HBSDI_FRAME_BITS 4'h9

`endif

//--- common/hbsdi_pkg.sv
// types shared by the host bus serial disk interface modules
// assumes the defines header for numeric constants
package hbsdi_pkg;
    // arbitration states, one-hot
    typedef enum logic [2:0] {
        HBSDI_ARB_IDLE = 3'b001,  // no grant yet, request raised while want is set
        HBSDI_ARB_SACK = 3'b010,  // grant seen, waiting for bus free
        HBSDI_ARB_MAST = 3'b100   // bus busy driven, vector out
    } hbsdi_arb_t;
endpackage

//--- common/hbsdi_buf_if.sv
// valid/ready byte stream carrier between the shift path and the buffer
// assumes a single clock domain shared by both ends
`timescale 1ns/1ps
interface hbsdi_buf_if #(parameter int W = 8);
    logic         valid;  // producer holds a word
    logic         ready;  // consumer can take it
    logic [W-1:0] data;   // word
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

//--- hw/hbsdi_skid.sv
// two-entry buffer with valid/ready on both sides
// assumes synchronous active-high reset on the shared clock
`timescale 1ns/1ps
module hbsdi_skid #(
    parameter int W = 8
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    hbsdi_buf_if.dst  in_side,
    hbsdi_buf_if.src  out_side
);
    logic [W-1:0] ent0;   // head entry
    logic [W-1:0] ent1;   // second entry
    logic [1:0]   count;  // occupancy 0..2
    wire push = in_side.valid && in_side.ready;
    wire pop  = out_side.valid && out_side.ready;

    // honest full/empty: ready drops only when both entries hold data
    assign in_side.ready  = (count != 2'h2);
    assign out_side.valid = (count != 2'h0);
    assign out_side.data  = ent0;

    // occupancy and entry movement
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= 2'h0;
            ent0  <= '0;
            ent1  <= '0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count == 2'h0) ent0 <= in_side.data;
                    else ent1 <= in_side.data;
                    count <= count + 2'h1;
                end
                2'b01: begin
                    ent0  <= ent1;
                    count <= count - 2'h1;
                end
                2'b11: begin
                    // head leaves, new word joins behind what remains
                    if (count == 2'h1) ent0 <= in_side.data;
                    else begin
                        ent0 <= ent1;
                        ent1 <= in_side.data;
                    end
                end
                default: begin
                    count <= count;
                end
            endcase
        end
    end
endmodule

//--- hw/hbsdi_arb.sv
// bus mastership arbitration for the interrupt sequence
// assumes grant and bus lines are already synchronous to ref_clk
`timescale 1ns/1ps
`include "hbsdi_defines.svh"
module hbsdi_arb (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic want,         // done and irq enable both set
    input  wire logic grant_in,     // bus grant from the priority chain
    input  wire logic bus_busy_in,  // bus busy seen on the bus
    input  wire logic slave_sync_in,// slave sync seen on the bus
    output logic      bus_request,  // request line
    output logic      master        // we own the bus
);
    hbsdi_pkg::hbsdi_arb_t state;
    hbsdi_pkg::hbsdi_arb_t next_state;
    wire bus_free = !bus_busy_in && !slave_sync_in && !grant_in;

    // state decode
    always_comb begin
        next_state = state;
        case (state)
            hbsdi_pkg::HBSDI_ARB_IDLE: begin
                if (want && grant_in) next_state = hbsdi_pkg::HBSDI_ARB_SACK;
            end
            hbsdi_pkg::HBSDI_ARB_SACK: begin
                if (bus_free) next_state = hbsdi_pkg::HBSDI_ARB_MAST;
            end
            hbsdi_pkg::HBSDI_ARB_MAST: begin
                // one vector cycle, then release the bus
                next_state = hbsdi_pkg::HBSDI_ARB_IDLE;
            end
            default: next_state = hbsdi_pkg::HBSDI_ARB_IDLE;
        endcase
    end

    // registered outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state       <= hbsdi_pkg::HBSDI_ARB_IDLE;
            bus_request <= 1'b0;
            master      <= 1'b0;
        end else begin
            state       <= next_state;
            // request gated by want and the idle state, so it drops once grant is seen
            bus_request <= want && (next_state == hbsdi_pkg::HBSDI_ARB_IDLE);
            master      <= (next_state == hbsdi_pkg::HBSDI_ARB_MAST);
        end
    end
endmodule

//--- test/hbsdi_top_properties.sv
// port checker for the host bus serial disk interface
// assumes it is bound onto hbsdi_top, whose port names it mirrors
`timescale 1ns/1ps
`include "hbsdi_defines.svh"
module hbsdi_chk #(
    parameter logic [9:0]  JUMPERS = `HBSDI_JUMPER_RESET, // jumper image, 1 = inserted
    parameter logic [15:0] VECTOR  = `HBSDI_VECTOR_RESET  // vector jumper image
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [17:0] addr,
    input wire logic        master_sync,
    input wire logic        c1,
    input wire logic        bus_init,
    input wire logic        grant_in,
    input wire logic        bus_busy_in,
    input wire logic        slave_sync_in,
    input wire logic        xfer_req,
    input wire logic        ctl_done,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe_n,
    input wire logic        reg_select,
    input wire logic        run,
    input wire logic        busy,
    input wire logic        bus_request,
    input wire logic        bus_busy_out,
    input wire logic        intr
);
    // decoder match: top bits high, jumper bits inverted
    wire hit      = master_sync && (addr[17:13] == 5'h1f) && (addr[12:3] == ~JUMPERS);
    // nobody else holds or answers on the bus
    wire bus_free = !grant_in && !bus_busy_in && !slave_sync_in;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // host read of status, read of buffer, idle buffer access
    sequence s_cs_read;
        hit && !c1 && !addr[1];
    endsequence
    sequence s_db_read;
        hit && !c1 && addr[1];
    endsequence
    sequence s_db_access;
        hit && addr[1] && !busy && !bus_init;
    endsequence
    chk_sel_hit: assert property (hit |=> reg_select)
        else $error("select missing on a matching address");
    chk_sel_miss: assert property (!hit |=> !reg_select)
        else $error("select without sync or with a wrong address");
    chk_busy_cause: assert property ((!xfer_req && !ctl_done) [*2] |-> busy)
        else $error("busy missing while request and done are low");
    chk_write_quiet: assert property (hit && c1 |=> data_oe_n == 16'hffff)
        else $error("data driven during a host write");
    chk_cs_lines: assert property (s_cs_read |=> data_oe_n == 16'h7f0f)
        else $error("wrong lines driven on a status read");
    chk_db_lines: assert property (s_db_read |=> data_oe_n[7:0] == 8'h00)
        else $error("buffer read leaves a line undriven");
    chk_run_set: assert property (s_db_access |-> ##[1:2] run)
        else $error("buffer access did not raise run");
    chk_init_run: assert property (bus_init |=> ##1 !run)
        else $error("run survives initialise");
    chk_req_idle: assert property ((!ctl_done) [*3] |-> !bus_request)
        else $error("bus request without done");
    chk_take_bus: assert property ($rose(bus_busy_out) |-> $past(bus_free, 2))
        else $error("bus taken while it was not free");
    chk_vec_out: assert property (bus_busy_out |-> intr && data_out[8:2] == VECTOR[8:2])
        else $error("vector or interrupt missing while master");
endmodule
bind hbsdi_top hbsdi_chk #(.JUMPERS(JUMPERS), .VECTOR(VECTOR)) u_chk (.*);

//--- test/hbsdi_ctl_model.sv
// behavioural disk controller on the serial side of the interface
// assumes the bench holds go_in until ctl_out rises and sets the pulse gap
`timescale 1ns/1ps
module hbsdi_ctl_model (
    input  wire logic       ref_clk,
    input  wire logic       run,            // run from the interface
    input  wire logic       serial_out_bit, // bits towards the controller
    input  wire logic       go_in,          // bench asks for an inbound byte
    input  wire logic [7:0] in_byte,        // byte sent inbound
    input  wire logic [3:0] gap,            // idle cycles before each pulse
    input  wire logic       err_in,         // bench asks for an error level
    output logic            xfer_req,
    output logic            ctl_done,
    output logic            ctl_out,
    output logic            ctl_error,
    output logic            shift_pulse,
    output logic            serial_in_bit,
    output logic [8:0]      got             // last frame seen, first bit on top
);
    // error is passed through as a level
    assign ctl_error = err_in;
    // one shift pulse, bit taken at its edge; a big gap mimics a slow controller
    task automatic pulse;
        repeat (gap) @(negedge ref_clk);
        shift_pulse = 1'b1;
        @(posedge ref_clk);
        got = {got[7:0], serial_out_bit};
        @(negedge ref_clk);
        shift_pulse = 1'b0;
    endtask
    // idle with done up; every run is answered by a busy spell
    initial begin
        xfer_req = 1'b0;
        ctl_done = 1'b1;
        ctl_out = 1'b0;
        shift_pulse = 1'b0;
        serial_in_bit = 1'b1;
        got = 9'h000;
        forever begin
            @(negedge ref_clk);
            if (run) begin
                xfer_req = 1'b0;
                ctl_done = 1'b0;
                if (!ctl_out)
                    repeat (9) pulse;
                else
                    repeat (4) @(negedge ref_clk);
                ctl_out = 1'b0;
                ctl_done = 1'b1;
            end else if (go_in) begin
                ctl_out = 1'b1;
                ctl_done = 1'b0;
                for (int i = 7; i >= 0; i--) begin
                    serial_in_bit = in_byte[i];
                    pulse;
                    // line no longer held: show the opposite level
                    serial_in_bit = ~in_byte[i];
                end
                xfer_req = 1'b1;
            end
        end
    end
endmodule

//--- test/hbsdi_tb_top.sv
// self-checking bench for the host bus serial disk interface
// assumes the controller model and the bound checker are compiled first
`timescale 1ns/1ps
`include "hbsdi_defines.svh"
module hbsdi_tb_top;
    // register addresses with every jumper removed
    localparam logic [17:0] CS_ADDR = 18'h3fff8 | `HBSDI_OFF_COMMAND_STATUS;
    localparam logic [17:0] DB_ADDR = 18'h3fff8 | `HBSDI_OFF_DATA_BUFFER;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [17:0] addr = 18'h00000;
    logic [15:0] data_in = 16'h0000;
    logic        master_sync = 1'b0, c1 = 1'b0, bus_init = 1'b0, host_ready = 1'b0;
    logic        grant_in = 1'b0, bus_busy_in = 1'b0, slave_sync_in = 1'b0;
    logic        go_in = 1'b0, err_in = 1'b0;
    logic [7:0]  in_byte = 8'h00, lfsr = 8'h07;
    logic [3:0]  gap = 4'h2;
    logic [15:0] data_out, data_oe_n, dout_q, oe_q;
    logic [8:0]  got;
    logic        reg_select, run, busy, serial_out_bit, bus_request, bus_busy_out, intr;
    logic        irq_enable, rd_valid, sel_q, xfer_req, ctl_done, ctl_out, ctl_error;
    logic        shift_pulse, serial_in_bit;
    int          bad_count = 0;
    int          checks_done = 0;
    // signals a wait can select: 0 done, 1 request, 2 master, 3 bus request
    wire  [3:0]  watch = {bus_request, bus_busy_out, xfer_req, ctl_done};
    hbsdi_top u_dut (.*);
    hbsdi_ctl_model u_ctl (.*);
    always #10 ref_clk = ~ref_clk;
    // next pseudo random byte
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // nine bits on the wire: byte, first bit on top, then odd parity
    function automatic logic [8:0] frame_of(input logic [7:0] b);
        return {b, ~^b};
    endfunction
    // status image: error, request, enable, done
    function automatic logic [15:0] status_of(input logic e, input logic t, input logic i, input logic d);
        return {e, 7'h00, t, i, d, 5'h00};
    endfunction
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("FAIL %0t seen %h want %h", $time, seen, want);
        end
    endtask
    // bounded wait on a watched signal, sampled on falling edges
    task automatic wait_on(input int sel, input logic want);
        for (int i = 0; i < 400; i++) begin
            if (watch[sel] === want)
                break;
            @(negedge ref_clk);
        end
    endtask
    // one host cycle: sync held two edges, answer taken after the second
    task automatic access(input logic [17:0] a, input logic wr, input logic [15:0] d);
        @(negedge ref_clk);
        addr = a;
        c1 = wr;
        data_in = d;
        master_sync = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        sel_q = reg_select;
        dout_q = data_out;
        oe_q = data_oe_n;
        @(negedge ref_clk);
        master_sync = 1'b0;
        addr = ~a;
        data_in = ~d;
    endtask
    // verdict, reached from the main sequence or the watchdog
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        check(data_oe_n, 16'hffff);
        check({11'h000, run, busy, bus_request, bus_busy_out, irq_enable}, 16'h0000);
        rst = 1'b0;
        // one random address bit off must never select
        for (int k = 0; k < 12; k++) begin
            lfsr = lfsr_next(lfsr);
            access(CS_ADDR ^ (18'h00008 << (lfsr % 15)), 1'b0, 16'h0000);
            check({15'h0000, sel_q}, 16'h0000);
            check(oe_q, 16'hffff);
        end
        access(CS_ADDR, 1'b0, 16'h0000);
        check({15'h0000, sel_q}, 16'h0001);
        check(oe_q, 16'h7f0f);
        check(dout_q & 16'h80e0, status_of(1'b0, 1'b0, 1'b0, 1'b1));
        @(negedge ref_clk);
        err_in = 1'b1;
        @(negedge ref_clk);
        err_in = 1'b0;
        access(CS_ADDR, 1'b0, 16'h0000);
        check(dout_q & 16'h8000, 16'h8000);
        $display("test decode and status ended");
        // outbound: both extremes, then random, the last with slow pulses
        for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            in_byte = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : lfsr;
            gap = (k == 3) ? 4'h6 : 4'h1;
            access(DB_ADDR, 1'b1, {~lfsr, in_byte});
            check(oe_q, 16'hffff);
            @(posedge ref_clk);
            #1;
            check({15'h0000, run}, 16'h0001);
            wait_on(0, 1'b0);
            wait_on(0, 1'b1);
            check({7'h00, got}, {7'h00, frame_of(in_byte)});
            check({15'h0000, run}, 16'h0000);
        end
        $display("test outbound ended");
        // inbound: the second byte waits while the host stalls
        for (int k = 0; k < 2; k++) begin
            lfsr = lfsr_next(lfsr);
            in_byte = lfsr;
            gap = 4'h2;
            @(negedge ref_clk);
            go_in = 1'b1;
            wait (ctl_out);
            go_in = 1'b0;
            wait_on(1, 1'b1);
            // the byte enters the buffer and its flag is registered two edges after the request
            repeat (4 * k + 2) @(negedge ref_clk);
            check({15'h0000, rd_valid}, 16'h0001);
            host_ready = 1'b1;
            access(DB_ADDR, 1'b0, 16'h0000);
            host_ready = 1'b0;
            check(oe_q, 16'hff00);
            check(dout_q & 16'h00ff, {8'h00, in_byte});
            wait_on(0, 1'b1);
        end
        $display("test inbound ended");
        // interrupt: enable, request, grant, wait for a free bus, master
        access(CS_ADDR, 1'b1, 16'h0040);
        access(CS_ADDR, 1'b0, 16'h0000);
        check(dout_q & 16'h80e0, status_of(1'b0, 1'b0, 1'b1, 1'b1));
        wait_on(3, 1'b1);
        check({15'h0000, bus_request}, 16'h0001);
        grant_in = 1'b1;
        bus_busy_in = 1'b1;
        repeat (3) @(negedge ref_clk);
        grant_in = 1'b0;
        repeat (3) @(negedge ref_clk);
        check({15'h0000, bus_busy_out}, 16'h0000);
        bus_busy_in = 1'b0;
        wait_on(2, 1'b1);
        check({15'h0000, intr}, 16'h0001);
        check(data_out & 16'h01fc, `HBSDI_VECTOR_RESET & 16'h01fc);
        // initialise during a buffer access keeps run low and drops the enable
        bus_init = 1'b1;
        access(DB_ADDR, 1'b0, 16'h0000);
        bus_init = 1'b0;
        repeat (2) @(negedge ref_clk);
        check({15'h0000, run}, 16'h0000);
        check({15'h0000, irq_enable}, 16'h0000);
        $display("test interrupt ended");
        end_of_test;
    end
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        end_of_test;
    end
endmodule
